//--- pkg/fmab_pkg.sv
// shared types and constants for the fabric multiply-accumulate block
package fmab_pkg;

    // ------------------------------------------------------------------
    // operand and result widths per mode
    // ------------------------------------------------------------------
    localparam int A_W = 19;
    localparam int B_W = 18;
    localparam int R_W = 48;
    localparam int SH_W = 4;
    localparam int DUAL_A0 = 11;
    localparam int DUAL_B0 = 10;
    localparam int DUAL_A1 = 8;
    localparam int DUAL_B1 = 8;
    localparam int DUAL_R = 24;
    localparam int QUAD_A0 = 7;
    localparam int QUAD_B0 = 6;
    localparam int QUAD_N = 4;
    localparam int QUAD_R = 12;
    localparam int QUAD_SMALL = 3;

    // ------------------------------------------------------------------
    // brain-float layout
    // ------------------------------------------------------------------
    localparam int BF_W = 16;
    localparam int BF_SIGN = 15;
    localparam int BF_EXP_LSB = 7;
    localparam int BF_FRAC_W = 7;
    localparam logic [9:0] BF_BIAS = 10'h07f;
    localparam logic [7:0] BF_EXP_MAX = 8'hff;
    localparam logic [5:0] BF_POINT = 6'h1e;
    localparam logic [5:0] BF_TOP = 6'h20;
    localparam logic [R_W-1:0] RESULT_RST = 48'h0;

    // ------------------------------------------------------------------
    // modes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        FMAB_NORMAL = 4'h1,
        FMAB_DUAL = 4'h2,
        FMAB_QUAD = 4'h4,
        FMAB_FLOAT = 4'h8
    } fmab_mode_t;

    typedef struct packed {
        fmab_mode_t mode;
        logic sgn;
        logic add_en;
        logic sub;
        logic acc;
        logic [SH_W-1:0] shift;
    } fmab_ctrl_t;

endpackage : fmab_pkg

//--- rtl/fmab_lane.sv
// one integer lane: product, optional add or subtract, arithmetic shift
`timescale 1ns/1ns
module fmab_lane #(
    parameter int AW = 4,
    parameter int BW = 4,
    parameter int RW = 12
) (
    input wire logic [AW-1:0] a_i, // multiplicand slice
    input wire logic [BW-1:0] b_i, // multiplier slice
    input wire logic sgn_i, // operands are two's complement
    input wire logic add_en_i, // route product into the adder
    input wire logic sub_i, // base minus product
    input wire logic [RW-1:0] base_i, // addend or running sum
    input wire logic [3:0] shift_i, // right shift amount
    output logic [RW-1:0] res_o // lane result
);

    logic signed [AW:0] a_ext;
    logic signed [BW:0] b_ext;
    logic signed [AW+BW+1:0] prod;
    logic signed [RW-1:0] prod_r;
    logic signed [RW-1:0] base_s;
    logic signed [RW-1:0] sum;

    // one extra bit lets unsigned operands share the signed multiplier
    assign a_ext = {sgn_i & a_i[AW-1], a_i};
    assign b_ext = {sgn_i & b_i[BW-1], b_i};
    assign prod = a_ext * b_ext;
    // narrow lanes keep the low bits of a wider product
    assign prod_r = RW'(prod);
    assign base_s = signed'(base_i);
    assign sum = add_en_i ? (sub_i ? base_s - prod_r : base_s + prod_r)
                          : prod_r;
    assign res_o = sum >>> shift_i;

endmodule : fmab_lane

//--- rtl/fmab_top.sv
// multiply-accumulate block: integer lanes, brain-float fma, result register
`timescale 1ns/1ns
// Function
// - one 19x18 product, 48-bit add or subtract
// - dual: 11x10 and 8x8, 24-bit adders
// - quad: 7x6 and three 4x4, 12-bit adders
// - float: one brain-float fused multiply-add
// - 4-bit arithmetic right shift per lane
// - operands signed or unsigned by setting
// - operands come from inputs A and B
// - product direct or into the adder
module fmab_top (
    input wire logic clock_i, // 100 MHz clock
    input wire logic reset_n_i, // asynchronous reset, active low
    input wire logic en_i, // clock enable for the result register
    input wire fmab_pkg::fmab_ctrl_t ctrl_i, // mode, signedness, adder setup
    input wire logic [fmab_pkg::A_W-1:0] a_i, // operand a
    input wire logic [fmab_pkg::B_W-1:0] b_i, // operand b
    input wire logic [fmab_pkg::R_W-1:0] c_i, // external addend
    output logic [fmab_pkg::R_W-1:0] result_o, // registered result
    output logic valid_o // result updated last edge
);

    // ------------------------------------------------------------------
    // accumulator base
    // ------------------------------------------------------------------
    logic [fmab_pkg::R_W-1:0] result_reg;
    logic [fmab_pkg::R_W-1:0] result_next;
    logic valid_reg;
    logic [fmab_pkg::R_W-1:0] base;
    logic [fmab_pkg::R_W-1:0] norm_res;
    logic [fmab_pkg::R_W-1:0] dual_res;
    logic [fmab_pkg::R_W-1:0] quad_res;
    logic [fmab_pkg::BF_W-1:0] flt_res;

    assign base = ctrl_i.acc ? result_reg : c_i;

    // ------------------------------------------------------------------
    // integer lanes
    // ------------------------------------------------------------------
    // all lanes see the one sgn bit, so packed functions cannot differ
    // in signedness
    fmab_lane #(.AW(fmab_pkg::A_W), .BW(fmab_pkg::B_W),
                .RW(fmab_pkg::R_W)) u_norm (
        .a_i(a_i),
        .b_i(b_i),
        .sgn_i(ctrl_i.sgn),
        .add_en_i(ctrl_i.add_en),
        .sub_i(ctrl_i.sub),
        .base_i(base),
        .shift_i(ctrl_i.shift),
        .res_o(norm_res)
    );

    fmab_lane #(.AW(fmab_pkg::DUAL_A0), .BW(fmab_pkg::DUAL_B0),
                .RW(fmab_pkg::DUAL_R)) u_dual0 (
        .a_i(a_i[10:0]),
        .b_i(b_i[9:0]),
        .sgn_i(ctrl_i.sgn),
        .add_en_i(ctrl_i.add_en),
        .sub_i(ctrl_i.sub),
        .base_i(base[23:0]),
        .shift_i(ctrl_i.shift),
        .res_o(dual_res[23:0])
    );

    fmab_lane #(.AW(fmab_pkg::DUAL_A1), .BW(fmab_pkg::DUAL_B1),
                .RW(fmab_pkg::DUAL_R)) u_dual1 (
        .a_i(a_i[18:11]),
        .b_i(b_i[17:10]),
        .sgn_i(ctrl_i.sgn),
        .add_en_i(ctrl_i.add_en),
        .sub_i(ctrl_i.sub),
        .base_i(base[47:24]),
        .shift_i(ctrl_i.shift),
        .res_o(dual_res[47:24])
    );

    fmab_lane #(.AW(fmab_pkg::QUAD_A0), .BW(fmab_pkg::QUAD_B0),
                .RW(fmab_pkg::QUAD_R)) u_quad0 (
        .a_i(a_i[6:0]),
        .b_i(b_i[5:0]),
        .sgn_i(ctrl_i.sgn),
        .add_en_i(ctrl_i.add_en),
        .sub_i(ctrl_i.sub),
        .base_i(base[11:0]),
        .shift_i(ctrl_i.shift),
        .res_o(quad_res[11:0])
    );

    for (genvar g = 0; g < fmab_pkg::QUAD_SMALL; g++) begin : g_quad
        fmab_lane #(.AW(fmab_pkg::QUAD_N), .BW(fmab_pkg::QUAD_N),
                    .RW(fmab_pkg::QUAD_R)) u_quad (
            .a_i(a_i[7+4*g +: 4]),
            .b_i(b_i[6+4*g +: 4]),
            .sgn_i(ctrl_i.sgn),
            .add_en_i(ctrl_i.add_en),
            .sub_i(ctrl_i.sub),
            .base_i(base[12+12*g +: 12]),
            .shift_i(ctrl_i.shift),
            .res_o(quad_res[12+12*g +: 12])
        );
    end

    // ------------------------------------------------------------------
    // brain-float fused multiply-add
    // ------------------------------------------------------------------
    // subnormals flush to zero and rounding truncates: cheap, and the
    // error stays within one unit in the last place
    logic [7:0] fa_e;
    logic [7:0] fb_e;
    logic [7:0] fc_e;
    logic [15:0] f_pm;
    logic f_pz;
    logic f_cz;
    logic f_sp;
    logic f_sc;
    logic signed [9:0] f_ex;
    logic signed [9:0] f_ey;
    logic y_big;
    logic signed [9:0] e_big;
    logic signed [9:0] e_diff;
    logic [31:0] m_big;
    logic [31:0] m_sml;
    logic [31:0] m_sh;
    logic s_big;
    logic [32:0] f_sum;
    logic f_sign;
    logic [5:0] f_lead;
    logic signed [9:0] f_e;
    logic [32:0] f_norm;

    assign fa_e = a_i[14:fmab_pkg::BF_EXP_LSB];
    assign fb_e = b_i[14:fmab_pkg::BF_EXP_LSB];
    assign fc_e = base[14:fmab_pkg::BF_EXP_LSB];
    assign f_pm = {8'h0, 1'b1, a_i[6:0]} * {8'h0, 1'b1, b_i[6:0]};
    assign f_pz = (fa_e == 8'h0) || (fb_e == 8'h0);
    assign f_cz = (fc_e == 8'h0) || !ctrl_i.add_en;
    assign f_sp = a_i[fmab_pkg::BF_SIGN] ^ b_i[fmab_pkg::BF_SIGN]
                  ^ (ctrl_i.sub & ctrl_i.add_en);
    assign f_sc = base[fmab_pkg::BF_SIGN];
    assign f_ex = signed'({2'h0, fa_e}) + signed'({2'h0, fb_e})
                  - signed'(fmab_pkg::BF_BIAS);
    assign f_ey = signed'({2'h0, fc_e});
    assign y_big = f_pz || (!f_cz && (f_ey > f_ex));
    assign e_big = y_big ? f_ey : f_ex;
    assign e_diff = y_big ? f_ey - f_ex : f_ex - f_ey;
    // both significands carry the binary point at bit 30
    assign m_big = y_big ? (f_cz ? 32'h0 : {2'h1, base[6:0], 23'h0})
                         : {f_pm, 16'h0};
    assign m_sml = y_big ? (f_pz ? 32'h0 : {f_pm, 16'h0})
                         : (f_cz ? 32'h0 : {2'h1, base[6:0], 23'h0});
    assign s_big = y_big ? f_sc : f_sp;
    assign m_sh = (e_diff > 10'sd31) ? 32'h0 : m_sml >> e_diff[4:0];

    always_comb begin
        if ((y_big ? f_sp : f_sc) == s_big) begin
            f_sum = {1'b0, m_big} + {1'b0, m_sh};
            f_sign = s_big;
        end else if (m_big >= m_sh) begin
            f_sum = {1'b0, m_big - m_sh};
            f_sign = s_big;
        end else begin
            f_sum = {1'b0, m_sh - m_big};
            f_sign = !s_big;
        end
        f_lead = 6'h0;
        for (int i = 0; i < 33; i++) begin
            if (f_sum[i]) begin
                f_lead = 6'(i);
            end
        end
    end

    assign f_e = e_big + signed'({4'h0, f_lead})
                 - signed'({4'h0, fmab_pkg::BF_POINT});
    assign f_norm = f_sum << (fmab_pkg::BF_TOP - f_lead);
    assign flt_res = (f_sum == 33'h0 || f_e <= 10'sd0) ? 16'h0 :
                     (f_e >= 10'sd255) ?
                         {f_sign, fmab_pkg::BF_EXP_MAX, 7'h0} :
                         {f_sign, f_e[7:0], f_norm[31:25]};

    // ------------------------------------------------------------------
    // mode select and result register
    // ------------------------------------------------------------------
    assign result_next =
        (ctrl_i.mode == fmab_pkg::FMAB_NORMAL) ? norm_res :
        (ctrl_i.mode == fmab_pkg::FMAB_DUAL) ? dual_res :
        (ctrl_i.mode == fmab_pkg::FMAB_QUAD) ? quad_res :
        (ctrl_i.mode == fmab_pkg::FMAB_FLOAT) ? {32'h0, flt_res} :
        fmab_pkg::RESULT_RST;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_reg <= fmab_pkg::RESULT_RST;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= en_i;
            if (en_i) begin
                result_reg <= result_next;
            end
        end
    end

    assign result_o = result_reg;
    assign valid_o = valid_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    logic plain;
    assign plain = en_i && !ctrl_i.sgn && !ctrl_i.acc && ctrl_i.shift == 4'h0;

    property p_norm_add;
        plain && ctrl_i.mode == fmab_pkg::FMAB_NORMAL && ctrl_i.add_en
            && !ctrl_i.sub |=> result_o == $past(c_i)
            + 48'($past(a_i)) * 48'($past(b_i));
    endproperty
    a_norm_add: assert property (p_norm_add)
        else $error("normal add result wrong");

    property p_norm_sub;
        plain && ctrl_i.mode == fmab_pkg::FMAB_NORMAL && ctrl_i.add_en
            && ctrl_i.sub |=> result_o == $past(c_i)
            - 48'($past(a_i)) * 48'($past(b_i));
    endproperty
    a_norm_sub: assert property (p_norm_sub)
        else $error("normal subtract result wrong");

    property p_dual;
        plain && ctrl_i.mode == fmab_pkg::FMAB_DUAL && !ctrl_i.add_en
            |=> result_o[23:0] == 24'($past(a_i[10:0])) * 24'($past(b_i[9:0]))
            && result_o[47:24]
               == 24'($past(a_i[18:11])) * 24'($past(b_i[17:10]));
    endproperty
    a_dual: assert property (p_dual)
        else $error("dual lane products wrong");

    property p_quad;
        plain && ctrl_i.mode == fmab_pkg::FMAB_QUAD && !ctrl_i.add_en
            |=> result_o[11:0] == 12'($past(a_i[6:0])) * 12'($past(b_i[5:0]))
            && result_o[23:12] == 12'($past(a_i[10:7])) * 12'($past(b_i[9:6]));
    endproperty
    a_quad: assert property (p_quad)
        else $error("quad lane products wrong");

    property p_shift;
        en_i && ctrl_i.sgn && !ctrl_i.add_en && ctrl_i.shift != 4'h0
            && ctrl_i.mode == fmab_pkg::FMAB_NORMAL
            |=> result_o == 48'((48'($signed($past(a_i)))
            * 48'($signed($past(b_i)))) >>> $past(ctrl_i.shift));
    endproperty
    a_shift: assert property (p_shift)
        else $error("signed shifted product wrong");

    property p_acc;
        en_i && ctrl_i.acc && ctrl_i.add_en && !ctrl_i.sub && !ctrl_i.sgn
            && ctrl_i.shift == 4'h0 && ctrl_i.mode == fmab_pkg::FMAB_NORMAL
            |=> result_o == $past(result_o)
            + 48'($past(a_i)) * 48'($past(b_i));
    endproperty
    a_acc: assert property (p_acc)
        else $error("accumulation wrong");

    property p_hold;
        !en_i |=> $stable(result_o) && !valid_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed without enable");

    property p_float_one;
        en_i && ctrl_i.mode == fmab_pkg::FMAB_FLOAT && !ctrl_i.add_en
            && a_i[15:0] == 16'h3f80 && b_i[14:7] != 8'h0
            && b_i[14:7] != 8'hff
            |=> result_o == {32'h0, $past(b_i[15:0])};
    endproperty
    a_float_one: assert property (p_float_one)
        else $error("float product by one wrong");

endmodule : fmab_top

//--- tb/fmab_user.sv
// user fabric logic model that feeds the multiply-accumulate block
`timescale 1ns/1ns
module fmab_user (
    input wire logic clock_i, // fabric clock
    output logic en_o, // clock enable of the block
    output fmab_pkg::fmab_ctrl_t ctrl_o, // mode and adder setup
    output logic [fmab_pkg::A_W-1:0] a_o, // operand a
    output logic [fmab_pkg::B_W-1:0] b_o, // operand b
    output logic [fmab_pkg::R_W-1:0] c_o // external addend
);
    initial begin
        en_o = 1'b0;
        ctrl_o = '0;
        a_o = '0;
        b_o = '0;
        c_o = '0;
    end

    // ------------------------------------------------------------------
    // one enabled edge per call
    // ------------------------------------------------------------------
    // a single sgn field serves every packed product
    task automatic send(input fmab_pkg::fmab_ctrl_t ct,
                        input logic [18:0] a, input logic [17:0] b,
                        input logic [47:0] c);
        @(posedge clock_i);
        en_o <= 1'b1;
        ctrl_o <= ct;
        a_o <= a;
        b_o <= b;
        c_o <= c;
        @(posedge clock_i);
        // released operands must not keep looking valid
        en_o <= 1'b0;
        a_o <= ~a;
        b_o <= ~b;
        c_o <= ~c;
    endtask : send
endmodule : fmab_user

//--- tb/fmab_top_bench.sv
// self-checking bench for the multiply-accumulate block
`timescale 1ns/1ns
module fmab_top_bench;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic en;
    fmab_pkg::fmab_ctrl_t ctrl;
    logic [18:0] a;
    logic [17:0] b;
    logic [47:0] c;
    logic [47:0] result;
    logic valid;
    int n_fail = 0;
    int samples_checked = 0;

    always #5 clock_i = ~clock_i;

    fmab_user u_fmab_user (.clock_i(clock_i), .en_o(en), .ctrl_o(ctrl),
        .a_o(a), .b_o(b), .c_o(c));
    fmab_top u_fmab_top (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .en_i(en), .ctrl_i(ctrl), .a_i(a), .b_i(b), .c_i(c),
        .result_o(result), .valid_o(valid));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic longint lane_f(longint x, longint y, int aw, int bw,
        int rw, bit sg, bit ad, bit sb, int sh, longint base);
        longint ea;
        longint eb;
        longint r;
        ea = x & ((64'h1 << aw) - 1);
        eb = y & ((64'h1 << bw) - 1);
        if (sg && ea[aw-1]) ea = ea - (64'h1 << aw);
        if (sg && eb[bw-1]) eb = eb - (64'h1 << bw);
        r = ad ? (sb ? base - ea * eb : base + ea * eb) : ea * eb;
        r = r & ((64'h1 << rw) - 1);
        if (r[rw-1]) r = r - (64'h1 << rw);
        r = r >>> sh;
        return r & ((64'h1 << rw) - 1);
    endfunction : lane_f

    function automatic fmab_pkg::fmab_ctrl_t mk(fmab_pkg::fmab_mode_t m,
        bit sg, bit ad, bit sb, bit ac, logic [3:0] sh);
        return {m, sg, ad, sb, ac, sh};
    endfunction : mk

    task automatic chk(string nm, logic [47:0] ex, logic [47:0] got);
        samples_checked++;
        if (got !== ex) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // answer is in the register just after the enabled edge, checked 1 ns later
    task automatic run(fmab_pkg::fmab_ctrl_t ct, logic [18:0] x,
                       logic [17:0] y, logic [47:0] z);
        u_fmab_user.send(ct, x, y, z);
        #1;
        chk("valid", 48'h1, {47'h0, valid});
    endtask : run

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_normal();
        logic [47:0] c0 = 48'h123456789abc;
        for (int k = 0; k < 6; k++) begin
            run(mk(fmab_pkg::FMAB_NORMAL, k % 2, k >= 2, k >= 4, 0, 0),
                19'h40001, 18'h3ffff, c0);
            chk("normal", 48'(lane_f(19'h40001, 18'h3ffff, 19, 18, 48,
                k % 2, k >= 2, k >= 4, 0, c0)),
                result);
        end
    endtask : t_normal

    task automatic t_dual();
        logic [47:0] c0 = 48'hfedcba987654;
        logic [18:0] x = 19'h5a5a5;
        logic [17:0] y = 18'h2c3d1;
        longint l0;
        longint l1;
        // the last pass is the bare product, unsigned and unshifted
        for (int k = 0; k < 3; k++) begin
            run(mk(fmab_pkg::FMAB_DUAL, k < 2, k < 2, k == 1, 0,
                k < 2 ? 4'h3 : 4'h0), x, y, c0);
            l0 = lane_f(x, y, 11, 10, 24, k < 2, k < 2, k == 1,
                k < 2 ? 3 : 0, c0[23:0]);
            l1 = lane_f(x >> 11, y >> 10, 8, 8, 24, k < 2, k < 2, k == 1,
                k < 2 ? 3 : 0, c0[47:24]);
            chk("dual", {l1[23:0], l0[23:0]}, result);
        end
    endtask : t_dual

    task automatic t_quad();
        logic [47:0] c0 = 48'h9e37a1c4b852;
        logic [18:0] x = 19'h6b3d9;
        logic [17:0] y = 18'h3a6e5;
        logic [47:0] ex;
        longint l;
        // the last pass is the bare product, unsigned and unshifted
        for (int s = 0; s < 3; s++) begin
            run(mk(fmab_pkg::FMAB_QUAD, s == 1, s < 2, s < 2, 0,
                s < 2 ? 4'h2 : 4'h0), x, y, c0);
            ex[11:0] = 12'(lane_f(x, y, 7, 6, 12, s == 1, s < 2, s < 2,
                s < 2 ? 2 : 0, c0[11:0]));
            for (int k = 1; k < 4; k++) begin
                l = lane_f(x >> (3 + 4 * k), y >> (2 + 4 * k), 4, 4, 12,
                    s == 1, s < 2, s < 2, s < 2 ? 2 : 0, c0 >> (12 * k));
                ex[12*k+:12] = l[11:0];
            end
            chk("quad", ex, result);
        end
    endtask : t_quad

    task automatic t_shift();
        for (int sh = 0; sh < 16; sh += 5) begin
            run(mk(fmab_pkg::FMAB_NORMAL, 1, 0, 0, 0, 4'(sh)), 19'h40000,
                18'h3, 48'h0);
            chk("shift", 48'(lane_f(19'h40000, 18'h3, 19, 18, 48, 1, 0, 0,
                sh, 0)), result);
        end
        // a code with two mode bits set is refused and loads zero
        run(mk(fmab_pkg::fmab_mode_t'(4'h3), 0, 0, 0, 0, 4'h0), 19'h1,
            18'h1, 48'h5);
        chk("illegal mode", 48'h0, result);
    endtask : t_shift

    task automatic t_float();
        // 1.0 * 2.0 added to 1.0, taken from 1.0, or product alone, where
        // the subtract setting must not touch a bare product
        logic [15:0] ex [4] = '{16'h4040, 16'hbf80, 16'h4000, 16'h4000};
        for (int k = 0; k < 4; k++) begin
            run(mk(fmab_pkg::FMAB_FLOAT, 0, k < 2, k % 2 == 1, 0, 4'h0),
                19'h03f80, 18'h04000, 48'h3f80);
            chk("float", {32'h0, ex[k]}, result);
        end
    endtask : t_float

    task automatic t_acc();
        @(posedge clock_i);
        reset_n_i <= 1'b0;
        @(posedge clock_i);
        reset_n_i <= 1'b1;
        #1;
        chk("clear", 48'h0, result);
        for (int k = 1; k < 3; k++) begin
            run(mk(fmab_pkg::FMAB_NORMAL, 0, 1, 0, 1, 4'h0), 19'h3, 18'h5,
                48'hbad0bad0bad0);
            chk("acc", 48'(15 * k), result);
        end
        @(posedge clock_i);
        #1;
        chk("hold", 48'h1e, result);
        chk("valid low", 48'h0, {47'h0, valid});
        @(posedge clock_i);
        reset_n_i <= 1'b0;
        #1;
        chk("reset", 48'h0, result);
        @(posedge clock_i);
        reset_n_i <= 1'b1;
    endtask : t_acc

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock_i);
        reset_n_i <= 1'b1;
        t_normal();
        t_dual();
        t_quad();
        t_shift();
        t_float();
        t_acc();
        wrap_up();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end
endmodule : fmab_top_bench
